// [rtl/smi_exec.sv]
// execution datapath for right shift, file copy and indirect load
// assumes decoder, file registers and data memory run on CLK_SYS;
// memory returns read data in the same cycle that MEM_RD is high.
// Operation
// - right shift: bit 0 to carry, bits move down, zero enters top
// - shift result goes to accumulator if dest is 0, file if 1
// - copy puts file value in accumulator if dest 0, rewrites file if 1
// - copy updates zero flag from the copied value
// - update kind: 00 pre-inc, 01 pre-dec, 10 post-inc, 11 post-dec
// - address is pointer+1 or pointer-1 for pre modes, the pointer itself for post modes, or pointer plus signed offset -32..31
// - pointer ends +1 for increments, -1 for decrements, unchanged for offset
// - window access reads pointed location into accumulator, updates zero
// - pointers are 16 bits and wrap around at both ends
// - one-bit index picks the pointer; only that one is used and updated
`timescale 1ns/1ns
module smi_exec
  import smi_pkg::*;
#(
  parameter int PTR_W  = SMI_PTR_W,
  parameter int OFFS_W = SMI_OFFS_W
) (
  // clock and reset
  input  wire logic                  CLK_SYS,
  input  wire logic                  RST_B,
  // decoded instruction and direct pointer loads
  input  wire smi_op_t               OP,
  input  wire smi_ptr_wr_t           PTR_WR,
  // data memory read port
  output logic                       MEM_RD,
  output logic       [PTR_W-1:0]     MEM_ADDR,
  input  wire logic [SMI_DATA_W-1:0] MEM_RDATA,
  // file register write-back
  output smi_wb_t                    FILE_WB,
  // architectural state
  output logic       [SMI_DATA_W-1:0] ACC,
  output logic                        CARRY,
  output logic                        ZERO,
  output logic       [PTR_W-1:0]      PTR0,
  output logic       [PTR_W-1:0]      PTR1,
  // handshake
  output logic                        BUSY,
  output logic                        DONE
);

  // elaboration checks
  if (PTR_W != SMI_PTR_W) begin : g_bad_ptr_w
    $error("PTR_W must match the package pointer width");
  end
  if (OFFS_W != SMI_OFFS_W || OFFS_W >= PTR_W) begin : g_bad_offs_w
    $error("OFFS_W must match the package and be narrower than PTR_W");
  end

  typedef enum logic {
    SMI_S_IDLE,
    SMI_S_WAIT
  } smi_state_t;

  smi_state_t            state;
  smi_state_t            next_state;
  logic [PTR_W-1:0]      ptr [2];
  logic [PTR_W-1:0]      cur_ptr;
  logic [PTR_W-1:0]      eff_addr;
  logic [PTR_W-1:0]      next_ptr;
  logic [SMI_DATA_W-1:0] alu_res;
  logic                  alu_carry;
  logic                  alu_zero;
  logic                  take;
  logic                  take_shift;
  logic                  take_copy;
  logic                  take_ind;
  logic [SMI_DATA_W-1:0] op_data;

  // an op is only taken while idle; requests during the wait are dropped
  assign take       = OP.valid && (state == SMI_S_IDLE) && (OP.kind != SMI_K_NONE);
  assign take_shift = take && (OP.kind == SMI_K_SHIFT);
  assign take_copy  = take && (OP.kind == SMI_K_COPY);
  assign take_ind   = take && (OP.kind == SMI_K_IND);
  assign op_data    = OP.fdata;
  assign cur_ptr    = ptr[OP.ptr_idx];

  // byte result for shift and copy
  smi_byte_alu u_alu (
    .kind      (OP.kind),
    .operand   (OP.fdata),
    .result    (alu_res),
    .carry_out (alu_carry),
    .zero_out  (alu_zero)
  );

  // address and pointer arithmetic
  smi_ptr_calc #(
    .PTR_W  (PTR_W),
    .OFFS_W (OFFS_W)
  ) u_ptr (
    .ptr      (cur_ptr),
    .upd_kind (OP.pointer_update_kind),
    .offs_en  (OP.offs_en),
    .offset   (OP.offset),
    .eff_addr (eff_addr),
    .next_ptr (next_ptr)
  );

  // next state: indirect load spends one cycle waiting for memory
  always_comb begin
    next_state = state;
    case (state)
      SMI_S_IDLE: begin
        if (take_ind) begin
          next_state = SMI_S_WAIT;
        end
      end
      SMI_S_WAIT: begin
        next_state = SMI_S_IDLE;
      end
      default: begin
        next_state = SMI_S_IDLE;
      end
    endcase
  end

  // state and busy flag
  always_ff @(posedge CLK_SYS) begin
    if (!RST_B) begin
      state <= SMI_S_IDLE;
      BUSY  <= 1'b0;
    end else begin
      state <= next_state;
      BUSY  <= (next_state == SMI_S_WAIT);
    end
  end

  // accumulator and flags
  always_ff @(posedge CLK_SYS) begin
    if (!RST_B) begin
      ACC   <= SMI_ACC_RST;
      CARRY <= 1'b0;
      ZERO  <= 1'b0;
    end else if (state == SMI_S_WAIT) begin
      // window is not a register: the pointed byte lands in the accumulator
      ACC  <= MEM_RDATA;
      ZERO <= smi_is_zero(MEM_RDATA);
    end else if (take_shift || take_copy) begin
      if (OP.dest == SMI_DEST_ACC) begin
        ACC <= alu_res;
      end
      if (take_shift) begin
        CARRY <= alu_carry;
      end
      ZERO <= alu_zero;
    end
  end

  // pointers: the op's own update wins over a direct load in the same cycle
  always_ff @(posedge CLK_SYS) begin
    if (!RST_B) begin
      ptr[0] <= SMI_PTR_RST;
      ptr[1] <= SMI_PTR_RST;
    end else if (take_ind) begin
      ptr[OP.ptr_idx] <= next_ptr;
      if (PTR_WR.valid && PTR_WR.idx != OP.ptr_idx) begin
        ptr[PTR_WR.idx] <= PTR_WR.data;
      end
    end else if (PTR_WR.valid) begin
      ptr[PTR_WR.idx] <= PTR_WR.data;
    end
  end

  assign PTR0 = ptr[0];
  assign PTR1 = ptr[1];

  // memory request issued on the taking edge, held for one cycle
  always_ff @(posedge CLK_SYS) begin
    if (!RST_B) begin
      MEM_RD   <= 1'b0;
      MEM_ADDR <= SMI_PTR_RST;
    end else begin
      MEM_RD <= take_ind;
      if (take_ind) begin
        MEM_ADDR <= eff_addr;
      end
    end
  end

  // file write-back and completion pulse
  always_ff @(posedge CLK_SYS) begin
    if (!RST_B) begin
      FILE_WB <= '0;
      DONE    <= 1'b0;
    end else begin
      FILE_WB.we   <= (take_shift || take_copy) && (OP.dest == SMI_DEST_FILE);
      FILE_WB.addr <= OP.faddr;
      FILE_WB.data <= alu_res;
      DONE         <= take_shift || take_copy || (state == SMI_S_WAIT);
    end
  end

  // checks
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RST_B);

  logic sh_acc;
  logic sh_file;
  logic cp_acc;
  logic ind_pre_inc;
  logic ind_post_dec0;
  logic ind_offs;
  logic ind_sel1;
  logic ind_pre_dec;
  logic ind_top0;
  logic busy_req;

  assign sh_acc        = take_shift && OP.dest == SMI_DEST_ACC;
  assign sh_file       = take_shift && OP.dest == SMI_DEST_FILE;
  assign cp_acc        = take_copy && OP.dest == SMI_DEST_ACC;
  assign ind_pre_inc   = take_ind && !OP.offs_en && OP.pointer_update_kind == SMI_PRE_INC;
  assign ind_post_dec0 = take_ind && !OP.offs_en && !OP.ptr_idx && !PTR_WR.valid
                         && OP.pointer_update_kind == SMI_POST_DEC;
  assign ind_offs      = take_ind && OP.offs_en && !PTR_WR.valid;
  assign ind_sel1      = take_ind && OP.ptr_idx && !PTR_WR.valid;
  assign ind_pre_dec   = take_ind && !OP.offs_en && OP.pointer_update_kind == SMI_PRE_DEC;
  assign ind_top0      = ind_pre_inc && !OP.ptr_idx && !PTR_WR.valid && (&PTR0);
  assign busy_req      = BUSY && OP.valid && (OP.kind != SMI_K_NONE);

  property p_shift_acc;
    sh_acc |=> (ACC == ($past(op_data) >> 1)) && (CARRY == $past(op_data[0]))
               && !FILE_WB.we;
  endproperty
  a_shift_acc: assert property (p_shift_acc) else $error("shift into acc wrong");

  property p_shift_file;
    sh_file |=> FILE_WB.we && (FILE_WB.data == ($past(op_data) >> 1))
                && (ACC == $past(ACC));
  endproperty
  a_shift_file: assert property (p_shift_file) else $error("shift to file wrong");

  property p_copy_acc;
    cp_acc |=> (ACC == $past(op_data)) && DONE && !FILE_WB.we;
  endproperty
  a_copy_acc: assert property (p_copy_acc) else $error("copy into acc wrong");

  property p_copy_zero;
    take_copy |=> ZERO == ($past(op_data) == '0) && (CARRY == $past(CARRY));
  endproperty
  a_copy_zero: assert property (p_copy_zero) else $error("copy zero flag wrong");

  property p_shift_zero;
    take_shift |=> ZERO == (($past(op_data) >> 1) == '0);
  endproperty
  a_shift_zero: assert property (p_shift_zero) else $error("shift zero flag wrong");

  property p_pre_inc_addr;
    ind_pre_inc |=> MEM_RD && (MEM_ADDR == PTR_W'($past(cur_ptr) + SMI_PTR_STEP));
  endproperty
  a_pre_inc_addr: assert property (p_pre_inc_addr) else $error("pre-inc address wrong");

  property p_post_dec;
    ind_post_dec0 |=> (MEM_ADDR == $past(PTR0))
                      && (PTR0 == PTR_W'($past(PTR0) - SMI_PTR_STEP));
  endproperty
  a_post_dec: assert property (p_post_dec) else $error("post-dec pointer wrong");

  property p_offs_keep;
    ind_offs |=> (PTR0 == $past(PTR0)) && (PTR1 == $past(PTR1));
  endproperty
  a_offs_keep: assert property (p_offs_keep) else $error("offset mode moved pointer");

  property p_sel_only;
    ind_sel1 |=> PTR0 == $past(PTR0);
  endproperty
  a_sel_only: assert property (p_sel_only) else $error("wrong pointer updated");

  property p_pre_dec_addr;
    ind_pre_dec |=> MEM_RD && (MEM_ADDR == PTR_W'($past(cur_ptr) - SMI_PTR_STEP));
  endproperty
  a_pre_dec_addr: assert property (p_pre_dec_addr) else $error("pre-dec address wrong");

  // top of the range must roll over to zero, never stick at all ones
  property p_wrap_top;
    ind_top0 |=> (MEM_ADDR == '0) && (PTR0 == '0);
  endproperty
  a_wrap_top: assert property (p_wrap_top) else $error("pointer did not wrap");

  // ops offered while the load waits must leave no trace
  property p_busy_drop;
    busy_req |=> !FILE_WB.we && !MEM_RD && (CARRY == $past(CARRY));
  endproperty
  a_busy_drop: assert property (p_busy_drop) else $error("op taken while busy");

  property p_rd_pulse;
    MEM_RD |=> !MEM_RD;
  endproperty
  a_rd_pulse: assert property (p_rd_pulse) else $error("read strobe held too long");

  sequence s_issue;
    MEM_RD && BUSY && !DONE;
  endsequence

  sequence s_return;
    DONE && !BUSY && !MEM_RD && (ACC == $past(MEM_RDATA))
    && (ZERO == smi_is_zero(ACC)) && !FILE_WB.we;
  endsequence

  property p_ind_load;
    take_ind |=> s_issue ##1 s_return;
  endproperty
  a_ind_load: assert property (p_ind_load) else $error("indirect load sequence wrong");

endmodule

// [inc/smi_pkg.sv]
// shift/move/indirect execution package: widths, encodings, carriers
// assumes the decoder and the core share CLK_SYS and RST_B with the datapath
package smi_pkg;

  // widths
  localparam int SMI_DATA_W  = 8;
  localparam int SMI_PTR_W   = 16;
  localparam int SMI_OFFS_W  = 6;
  localparam int SMI_FADDR_W = 7;

  // operation kinds issued by the decoder
  typedef enum logic [1:0] {
    SMI_K_NONE,
    SMI_K_SHIFT,
    SMI_K_COPY,
    SMI_K_IND
  } smi_kind_t;

  // pointer_update_kind encodings
  localparam logic [1:0] SMI_PRE_INC  = 2'h0;
  localparam logic [1:0] SMI_PRE_DEC  = 2'h1;
  localparam logic [1:0] SMI_POST_INC = 2'h2;
  localparam logic [1:0] SMI_POST_DEC = 2'h3;

  // destination select and fixed values
  localparam logic                  SMI_DEST_ACC   = 1'b0;
  localparam logic                  SMI_DEST_FILE  = 1'b1;
  localparam logic                  SMI_SHIFT_FILL = 1'b0;
  localparam logic [SMI_DATA_W-1:0] SMI_ACC_RST    = 8'h00;
  localparam logic [SMI_PTR_W-1:0]  SMI_PTR_RST    = 16'h0000;
  localparam logic [SMI_PTR_W-1:0]  SMI_PTR_STEP   = 16'h0001;

  // one decoded instruction
  typedef struct packed {
    logic                   valid;
    smi_kind_t              kind;
    logic                   dest;
    logic [SMI_FADDR_W-1:0] faddr;
    logic [SMI_DATA_W-1:0]  fdata;
    logic                   ptr_idx;
    logic [1:0]             pointer_update_kind;
    logic                   offs_en;
    logic [SMI_OFFS_W-1:0]  offset;
  } smi_op_t;

  // direct pointer load from other instructions
  typedef struct packed {
    logic                 valid;
    logic                 idx;
    logic [SMI_PTR_W-1:0] data;
  } smi_ptr_wr_t;

  // file register write-back
  typedef struct packed {
    logic                   we;
    logic [SMI_FADDR_W-1:0] addr;
    logic [SMI_DATA_W-1:0]  data;
  } smi_wb_t;

  // zero test shared by every zero flag update
  function automatic logic smi_is_zero(input logic [SMI_DATA_W-1:0] v);
    return v == '0;
  endfunction

endpackage

// [rtl/smi_byte_alu.sv]
// byte result path for the shift and copy operations
// assumes a purely combinational use; the caller registers the results
`timescale 1ns/1ns
module smi_byte_alu
  import smi_pkg::*;
(
  // operation
  input  wire smi_kind_t             kind,
  input  wire logic [SMI_DATA_W-1:0] operand,
  // results
  output logic       [SMI_DATA_W-1:0] result,
  output logic                        carry_out,
  output logic                        zero_out
);

  // shift drops bit 0 into carry; copy passes through unchanged
  always_comb begin
    result    = operand;
    carry_out = operand[0];
    if (kind == SMI_K_SHIFT) begin
      result = {SMI_SHIFT_FILL, operand[SMI_DATA_W-1:1]};
    end
    zero_out = smi_is_zero(result);
  end

endmodule

// [rtl/smi_ptr_calc.sv]
// effective address and next pointer value for the indirect load
// assumes the caller selects the pointer and commits next_ptr itself
`timescale 1ns/1ns
module smi_ptr_calc
  import smi_pkg::*;
#(
  parameter int PTR_W  = SMI_PTR_W,
  parameter int OFFS_W = SMI_OFFS_W
) (
  // pointer and addressing mode
  input  wire logic [PTR_W-1:0]  ptr,
  input  wire logic [1:0]        upd_kind,
  input  wire logic              offs_en,
  input  wire logic [OFFS_W-1:0] offset,
  // results
  output logic       [PTR_W-1:0] eff_addr,
  output logic       [PTR_W-1:0] next_ptr
);

  // sign extension needs at least one spare bit above the offset
  if (OFFS_W < 1 || OFFS_W >= PTR_W) begin : g_bad_w
    $error("OFFS_W must be at least 1 and narrower than PTR_W");
  end

  logic [PTR_W-1:0] ptr_inc;
  logic [PTR_W-1:0] ptr_dec;
  logic [PTR_W-1:0] offs_ext;

  // plain modulo arithmetic, so the pointer wraps at both ends
  assign ptr_inc  = PTR_W'(ptr + PTR_W'(SMI_PTR_STEP));
  assign ptr_dec  = PTR_W'(ptr - PTR_W'(SMI_PTR_STEP));
  assign offs_ext = PTR_W'({{(PTR_W-OFFS_W){offset[OFFS_W-1]}}, offset});

  // address formation and pointer update per mode
  always_comb begin
    eff_addr = ptr;
    next_ptr = ptr;
    if (offs_en) begin
      eff_addr = PTR_W'(ptr + offs_ext);
    end else begin
      case (upd_kind)
        SMI_PRE_INC: begin
          eff_addr = ptr_inc;
          next_ptr = ptr_inc;
        end
        SMI_PRE_DEC: begin
          eff_addr = ptr_dec;
          next_ptr = ptr_dec;
        end
        SMI_POST_INC: begin
          next_ptr = ptr_inc;
        end
        SMI_POST_DEC: begin
          next_ptr = ptr_dec;
        end
        default: begin
          next_ptr = ptr;
        end
      endcase
    end
  end

endmodule

// [dv/smi_exec_tb_top.sv]
// self-checking bench for the shift, copy and indirect load datapath
// assumes smi_pkg is compiled first; the bench plays decoder and data memory
`timescale 1ns/1ns
module smi_exec_tb_top
  import smi_pkg::*;
;
  // clock, reset and design-facing signals
  logic                  clk_sys = 1'b0;
  logic                  rst_b   = 1'b0;
  smi_op_t               op      = '0;
  smi_ptr_wr_t           ptr_wr  = '0;
  logic                  mem_rd;
  logic [SMI_PTR_W-1:0]  mem_addr;
  logic [SMI_DATA_W-1:0] mem_rdata = 8'ha5;
  smi_wb_t               file_wb;
  logic [SMI_DATA_W-1:0] acc;
  logic                  carry;
  logic                  zero;
  logic [SMI_PTR_W-1:0]  ptr0;
  logic [SMI_PTR_W-1:0]  ptr1;
  logic                  busy;
  logic                  done;
  // bench model of the architectural state
  logic [SMI_DATA_W-1:0] acc_m   = 8'h00;
  logic                  carry_m = 1'b0;
  logic [SMI_PTR_W-1:0]  p_m [2];
  logic [SMI_PTR_W-1:0]  ea_m;
  int                    error_cnt  = 0;
  int                    n_compared = 0;

  always #5 clk_sys = ~clk_sys;

  smi_exec u_smi_exec (
    .CLK_SYS   (clk_sys),
    .RST_B     (rst_b),
    .OP        (op),
    .PTR_WR    (ptr_wr),
    .MEM_RD    (mem_rd),
    .MEM_ADDR  (mem_addr),
    .MEM_RDATA (mem_rdata),
    .FILE_WB   (file_wb),
    .ACC       (acc),
    .CARRY     (carry),
    .ZERO      (zero),
    .PTR0      (ptr0),
    .PTR1      (ptr1),
    .BUSY      (busy),
    .DONE      (done)
  );

  // one comparison, counted either way
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("compared %0d, errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // present one op for one edge; indirect ops get memory data in the wait cycle
  task automatic issue(input smi_op_t o, input logic [7:0] md);
    @(posedge clk_sys);
    op <= o;
    @(posedge clk_sys);
    op <= '0;
    if (o.kind == SMI_K_IND) begin
      mem_rdata <= md;
    end
    #1;
    if (o.kind == SMI_K_IND) begin
      check(mem_rd, 1'b1);
      check(busy, 1'b1);
      check(done, 1'b0);
      check(mem_addr, ea_m);
      @(posedge clk_sys);
      mem_rdata <= ~md; // released bus no longer shows the old byte
      #1;
      check(busy, 1'b0);
    end
    check(done, 1'b1);
  endtask

  // direct pointer load, one-cycle pulse
  task automatic load_ptr(input logic idx, input logic [15:0] d);
    @(posedge clk_sys);
    ptr_wr <= '{valid: 1'b1, idx: idx, data: d};
    @(posedge clk_sys);
    ptr_wr <= '0;
    p_m[idx] = d;
  endtask

  // main sequence
  initial begin
    smi_op_t        o;
    logic [7:0]     v;
    logic [7:0]     r;
    logic [15:0]    p;
    logic [7:0]     vals [4];
    vals = '{8'h03, 8'h80, 8'h01, 8'hff};
    repeat (6) @(posedge clk_sys);
    rst_b <= 1'b1;
    #1;
    check({acc, carry, zero, busy, done, mem_rd}, 16'h0000);
    check(ptr0, 16'h0000);
    check(ptr1, 16'h0000);
    // shift and copy over both destinations and edge operands
    for (int k = 0; k < 2; k++) begin
      for (int i = 0; i < 8; i++) begin
        v = (k == 1 && i[0]) ? 8'h00 : vals[i % 4];
        o = '0;
        o.valid = 1'b1;
        o.kind  = (k == 0) ? SMI_K_SHIFT : SMI_K_COPY;
        o.dest  = i[2];
        o.faddr = 7'h10 + 7'(i);
        o.fdata = v;
        issue(o, 8'h00);
        r = (k == 0) ? {SMI_SHIFT_FILL, v[7:1]} : v;
        if (k == 0) carry_m = v[0];
        if (!o.dest) acc_m = r;
        check(acc, acc_m);
        check(carry, carry_m);
        check(zero, r == 8'h00);
        check(file_wb.we, o.dest);
        if (o.dest) check({file_wb.addr, file_wb.data}, {o.faddr, r});
      end
    end
    // kind none is ignored
    @(posedge clk_sys);
    op <= '{valid: 1'b1, kind: SMI_K_NONE, default: '0};
    @(posedge clk_sys);
    op <= '0;
    #1;
    check(done, 1'b0);
    check(acc, acc_m);
    // pointers start at the wrap corners
    load_ptr(1'b0, 16'hffff);
    load_ptr(1'b1, 16'h1234);
    #1;
    check(ptr0, 16'hffff);
    check(ptr1, 16'h1234);
    load_ptr(1'b1, 16'h0000);
    #1;
    check(ptr1, 16'h0000);
    // every update kind, then both offset extremes, on each pointer
    for (int idx = 0; idx < 2; idx++) begin
      for (int m = 0; m < 6; m++) begin
        p = p_m[idx];
        o = '0;
        o.valid   = 1'b1;
        o.kind    = SMI_K_IND;
        o.ptr_idx = idx[0];
        o.pointer_update_kind = 2'(m);
        o.offs_en = (m >= 4);
        o.offset  = (m == 4) ? 6'h20 : 6'h1f;
        case (m)
          0: begin
            ea_m     = p + 16'h0001;
            p_m[idx] = ea_m;
          end
          1: begin
            ea_m     = p - 16'h0001;
            p_m[idx] = ea_m;
          end
          2: begin
            ea_m     = p;
            p_m[idx] = p + 16'h0001;
          end
          3: begin
            ea_m     = p;
            p_m[idx] = p - 16'h0001;
          end
          4: begin
            ea_m = p - 16'h0020;
          end
          default: begin
            ea_m = p + 16'h001f;
          end
        endcase
        v = (m == idx) ? 8'h00 : 8'h40 + 8'(m);
        issue(o, v);
        check(acc, v);
        check(zero, v == 8'h00);
        check(carry, carry_m);
        check(ptr0, p_m[0]);
        check(ptr1, p_m[1]);
        acc_m = v;
      end
    end
    // a shift offered in the wait cycle is dropped; the load still lands
    @(posedge clk_sys);
    op <= o;
    @(posedge clk_sys);
    op        <= '{valid: 1'b1, kind: SMI_K_SHIFT, dest: SMI_DEST_FILE, fdata: 8'h02,
                   default: '0};
    mem_rdata <= 8'h3c;
    @(posedge clk_sys);
    op        <= '0;
    mem_rdata <= 8'hc3;
    #1;
    check(acc, 8'h3c);
    check({carry, zero, file_wb.we}, {carry_m, 2'b00});
    check(ptr1, p_m[1]);
    // mid-run reset brings back every reset value except FILE_WB, which is not checked
    @(posedge clk_sys);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_b <= 1'b1;
    #1;
    check({acc, carry, zero, busy, done, mem_rd}, 16'h0000);
    check(ptr0, 16'h0000);
    check(ptr1, 16'h0000);
    check(mem_addr, 16'h0000);
    finish_test();
  end

  // watchdog, far beyond the roughly ninety cycles the tests need
  initial begin
    #20000;
    error_cnt++;
    finish_test();
  end
endmodule
